// [common/ifsr_params.svh]
`ifndef IFSR_PARAMS_SVH
`define IFSR_PARAMS_SVH

`define IFSR_CLA_ISO        8'h00
`define IFSR_INS_SELECT     8'hA4
`define IFSR_INS_READ       8'hB0
`define IFSR_P1_BY_FID      8'h00
`define IFSR_P1_CHILD_DF    8'h01
`define IFSR_P1_EF_IN_DF    8'h02
`define IFSR_P1_PARENT_DF   8'h03
`define IFSR_P1_BY_NAME     8'h04
`define IFSR_P2_RETURN_FCI  8'h00
`define IFSR_P2_NO_DATA     8'h0C
`define IFSR_SFI_CURRENT    5'h00
`define IFSR_SFI_RESERVED   5'h1F
`define IFSR_MAX_LC         16'h0010

`define IFSR_SW_OK          16'h9000
`define IFSR_SW_BAD_LEN     16'h6700
`define IFSR_SW_USE_COND    16'h6985
`define IFSR_SW_NOT_FOUND   16'h6A82
`define IFSR_SW_BAD_PARAMS  16'h6A86
`define IFSR_SW_LEN_PARAM   16'h6A87
`define IFSR_SW_BAD_INS     16'h6D00
`define IFSR_SW_BAD_CLASS   16'h6E00

`define IFSR_HDR_BYTES      5'h04
`define IFSR_BODY_MAX       5'h13
`define IFSR_CNT_MAX        5'h17
`define IFSR_MEM_DEPTH      512

// file identifiers and name are arbitrary values for this build
`define IFSR_MF_FID         16'h3F00
`define IFSR_DF_FID         16'hE110
`define IFSR_DF_NAME        56'hA0000001020304
`define IFSR_DF_NAME_LEN    16'h0007

`define IFSR_EF_COUNT       4
`define IFSR_FCI_IDX        2'h3
`define IFSR_EF0_FID        16'hE104
`define IFSR_EF0_SFI        5'h01
`define IFSR_EF0_BASE       9'h000
`define IFSR_EF0_SIZE       10'h080
`define IFSR_EF1_FID        16'hE103
`define IFSR_EF1_SFI        5'h02
`define IFSR_EF1_BASE       9'h080
`define IFSR_EF1_SIZE       10'h040
`define IFSR_EF2_FID        16'hE105
`define IFSR_EF2_SFI        5'h03
`define IFSR_EF2_BASE       9'h0C0
`define IFSR_EF2_SIZE       10'h100
`define IFSR_EF3_FID        16'h001F
`define IFSR_EF3_SFI        5'h1F
`define IFSR_EF3_BASE       9'h1C0
`define IFSR_EF3_SIZE       10'h020

`endif

// [common/ifsr_pkg.sv]
package ifsr_pkg;

    typedef enum logic [2:0] {
        IFSR_COLLECT = 3'b000,
        IFSR_EXEC    = 3'b001,
        IFSR_DATA    = 3'b010,
        IFSR_SW1     = 3'b011,
        IFSR_SW2     = 3'b100
    } ifsr_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } ifsr_byte_t;

    typedef struct packed {
        logic       we;
        logic [8:0] addr;
        logic [7:0] wdata;
    } ifsr_load_t;

    typedef struct packed {
        logic [15:0] fid;
        logic [4:0]  sfi;
        logic [8:0]  base;
        logic [9:0]  size;
    } ifsr_ef_t;

    typedef struct packed {
        ifsr_state_t      st;
        logic [4:0]       cnt;
        logic             ovf;
        logic [7:0]       cla;
        logic [7:0]       ins;
        logic [7:0]       p1;
        logic [7:0]       p2;
        logic [18:0][7:0] body;
        logic             df_sel;
        logic             ef_ok;
        logic [1:0]       ef_idx;
        logic [8:0]       rd_addr;
        logic [9:0]       rd_left;
        logic [15:0]      sw;
        ifsr_byte_t       out;
        logic             out_valid;
    } ifsr_regs_t;

endpackage

// [rtl/ifsr_top.sv]
// Notes on behaviour
// - CLA 00 INS A4 is file select
// - P1 00/01/02: by fid, child DF, EF
// - P1 03 parent DF, 04 by DF name
// - P2 00 returns file 1F, 0C nothing
// - empty data with P1 00/03 selects MF
// - P1 04 data is DF name
// - success: optional control info then 9000
// - bad or inconsistent lengths give 6700
// - chain in progress gives 6985
// - missing file gives 6A82, selection kept
// - bad P1/P2 6A86, bad class 6E00
// - Lc inconsistent with P1/P2 gives 6A87
// - CLA 00 INS B0 is binary read
// - P1 bit7 set: reserved 00, SFI, 8-bit offset
// - P1 bit7 clear: 15-bit offset
// - SFI 0 current, 1-1E select, 1F reserved
// - Le zero returns rest of file
// - Le beyond remainder is clamped
// - offset past file end gives 6985
`timescale 1ns/10ps
`include "ifsr_params.svh"

module ifsr_top
(
    input  wire logic                clk_sys,    // 250 MHz system clock
    input  wire logic                rstn,       // async reset, active low
    input  wire ifsr_pkg::ifsr_byte_t cmd_in,    // command byte, last marks end of APDU
    input  wire logic                cmd_valid,  // command byte offered
    output logic                     cmd_ready,  // command byte taken
    output ifsr_pkg::ifsr_byte_t     rsp_out,    // response byte, last on SW2
    output logic                     rsp_valid,  // response byte offered
    input  wire logic                rsp_ready,  // response byte taken
    input  wire logic                chain_busy, // wrapped chain or multi-pass ongoing
    input  wire ifsr_pkg::ifsr_load_t mem_load,  // file content load port
    output logic                     df_selected,// DF (not MF) is current
    output logic                     ef_selected // an EF is current
);
    import ifsr_pkg::*;

    ifsr_regs_t r_q;
    ifsr_regs_t r_d;
    logic [7:0] mem [`IFSR_MEM_DEPTH];
    localparam logic [55:0] df_name = `IFSR_DF_NAME;

    function automatic ifsr_ef_t ef_info(input logic [1:0] idx);
        ifsr_ef_t e;
        case (idx)
            2'h0:    e = '{`IFSR_EF0_FID, `IFSR_EF0_SFI, `IFSR_EF0_BASE, `IFSR_EF0_SIZE};
            2'h1:    e = '{`IFSR_EF1_FID, `IFSR_EF1_SFI, `IFSR_EF1_BASE, `IFSR_EF1_SIZE};
            2'h2:    e = '{`IFSR_EF2_FID, `IFSR_EF2_SFI, `IFSR_EF2_BASE, `IFSR_EF2_SIZE};
            default: e = '{`IFSR_EF3_FID, `IFSR_EF3_SFI, `IFSR_EF3_BASE, `IFSR_EF3_SIZE};
        endcase
        return e;
    endfunction

    // control info file is never reachable by fid or sfi lookups
    function automatic logic [2:0] ef_find(input logic by_sfi, input logic [15:0] fid, input logic [4:0] sfi);
        ifsr_ef_t e;
        logic [2:0] res;
        res = 3'h0;
        for (int i = `IFSR_EF_COUNT - 2; i >= 0; i--)
        begin
            e = ef_info(2'(i));
            if (by_sfi ? (e.sfi == sfi) : (e.fid == fid))
            begin
                res = {1'b1, 2'(i)};
            end
        end
        return res;
    endfunction

    always_ff @(posedge clk_sys)
    begin
        if (mem_load.we)
        begin
            mem[mem_load.addr] <= mem_load.wdata;
        end
    end

    logic [4:0]  nb;
    logic [15:0] lc;
    logic [15:0] le;
    logic        le_pres;
    logic        len_bad;
    logic [4:0]  ds;
    logic [4:0]  k;
    logic [15:0] fid;
    logic [2:0]  hit;
    logic        name_ok;
    logic [14:0] off;
    logic [9:0]  rem;
    logic [15:0] sw_v;
    logic        send;
    logic [8:0]  start;
    logic [9:0]  cnt_v;
    ifsr_ef_t    e;

    always_comb
    begin
        r_d = r_q;
        nb = (r_q.cnt >= `IFSR_HDR_BYTES) ? r_q.cnt - `IFSR_HDR_BYTES : 5'h00;
        lc = 16'h0000;
        le = 16'h0000;
        le_pres = 1'b0;
        len_bad = r_q.ovf || (r_q.cnt < `IFSR_HDR_BYTES);
        ds = 5'h01;
        k = 5'h00;
        fid = 16'h0000;
        hit = 3'h0;
        name_ok = 1'b0;
        off = 15'h0000;
        rem = 10'h000;
        sw_v = `IFSR_SW_OK;
        send = 1'b0;
        start = 9'h000;
        cnt_v = 10'h000;
        e = ef_info(r_q.ef_idx);

        // short and extended length field decode
        if (nb == 5'h01)
        begin
            le_pres = 1'b1;
            le = {8'h00, r_q.body[0]};
        end
        else if (nb != 5'h00 && r_q.body[0] != 8'h00)
        begin
            lc = {8'h00, r_q.body[0]};
            k = 5'(lc) + 5'h01;
            if ({11'h000, nb} == lc + 16'h0002)
            begin
                le_pres = 1'b1;
                le = {8'h00, r_q.body[k]};
            end
            else if ({11'h000, nb} != lc + 16'h0001)
            begin
                len_bad = 1'b1;
            end
        end
        else if (nb == 5'h03)
        begin
            le_pres = 1'b1;
            le = {r_q.body[1], r_q.body[2]};
        end
        else if (nb != 5'h00)
        begin
            ds = 5'h03;
            lc = {r_q.body[1], r_q.body[2]};
            k = 5'(lc) + 5'h03;
            if ({11'h000, nb} == lc + 16'h0005)
            begin
                le_pres = 1'b1;
                le = {r_q.body[k], r_q.body[k + 5'h01]};
            end
            else if ({11'h000, nb} != lc + 16'h0003 || lc == 16'h0000)
            begin
                len_bad = 1'b1;
            end
        end
        fid = {r_q.body[ds], r_q.body[ds + 5'h01]};
        name_ok = (lc == `IFSR_DF_NAME_LEN);
        for (int i = 0; i < 7; i++)
        begin
            if (r_q.body[ds + 5'(i)] != df_name[8 * (6 - i) +: 8])
            begin
                name_ok = 1'b0;
            end
        end

        if (r_q.out_valid && rsp_ready)
        begin
            r_d.out_valid = 1'b0;
        end
        case (r_q.st)
            IFSR_COLLECT:
            begin
                if (cmd_valid)
                begin
                    case (r_q.cnt)
                        5'h00:   r_d.cla = cmd_in.data;
                        5'h01:   r_d.ins = cmd_in.data;
                        5'h02:   r_d.p1 = cmd_in.data;
                        5'h03:   r_d.p2 = cmd_in.data;
                        default:
                        begin
                            if (r_q.cnt < `IFSR_CNT_MAX)
                            begin
                                r_d.body[nb] = cmd_in.data;
                            end
                        end
                    endcase
                    if (r_q.cnt == `IFSR_CNT_MAX)
                    begin
                        r_d.ovf = 1'b1;
                    end
                    else
                    begin
                        r_d.cnt = r_q.cnt + 5'h01;
                    end
                    if (cmd_in.last)
                    begin
                        r_d.st = IFSR_EXEC;
                    end
                end
            end
            IFSR_EXEC:
            begin
                if (r_q.cla != `IFSR_CLA_ISO)
                begin
                    sw_v = `IFSR_SW_BAD_CLASS;
                end
                else if (r_q.ins != `IFSR_INS_SELECT && r_q.ins != `IFSR_INS_READ)
                begin
                    sw_v = `IFSR_SW_BAD_INS;
                end
                else if (chain_busy)
                begin
                    sw_v = `IFSR_SW_USE_COND;
                end
                else if (len_bad)
                begin
                    sw_v = `IFSR_SW_BAD_LEN;
                end
                else if (r_q.ins == `IFSR_INS_SELECT)
                begin
                    if (r_q.p1 > `IFSR_P1_BY_NAME ||
                        (r_q.p2 != `IFSR_P2_RETURN_FCI && r_q.p2 != `IFSR_P2_NO_DATA))
                    begin
                        sw_v = `IFSR_SW_BAD_PARAMS;
                    end
                    else if (lc > `IFSR_MAX_LC ||
                             (r_q.p1 == `IFSR_P1_BY_NAME && lc == 16'h0000) ||
                             (r_q.p1 == `IFSR_P1_PARENT_DF && lc != 16'h0000) ||
                             (r_q.p1 <= `IFSR_P1_EF_IN_DF && lc != 16'h0002 &&
                              !(r_q.p1 == `IFSR_P1_BY_FID && lc == 16'h0000)))
                    begin
                        sw_v = `IFSR_SW_LEN_PARAM;
                    end
                    else if (r_q.p1 == `IFSR_P1_PARENT_DF || lc == 16'h0000 ||
                             (r_q.p1 == `IFSR_P1_BY_FID && fid == `IFSR_MF_FID))
                    begin
                        r_d.df_sel = 1'b0;
                        r_d.ef_ok = 1'b0;
                    end
                    else if ((r_q.p1 == `IFSR_P1_BY_NAME && name_ok) ||
                             (r_q.p1 != `IFSR_P1_BY_NAME && r_q.p1 != `IFSR_P1_EF_IN_DF &&
                              fid == `IFSR_DF_FID))
                    begin
                        r_d.df_sel = 1'b1;
                        r_d.ef_ok = 1'b0;
                    end
                    else
                    begin
                        hit = ef_find(1'b0, fid, 5'h00);
                        if (r_q.p1 != `IFSR_P1_CHILD_DF && r_q.p1 != `IFSR_P1_BY_NAME &&
                            r_q.df_sel && hit[2])
                        begin
                            r_d.ef_ok = 1'b1;
                            r_d.ef_idx = hit[1:0];
                        end
                        else
                        begin
                            sw_v = `IFSR_SW_NOT_FOUND;
                        end
                    end
                    if (sw_v == `IFSR_SW_OK && r_q.p2 == `IFSR_P2_RETURN_FCI)
                    begin
                        e = ef_info(`IFSR_FCI_IDX);
                        send = 1'b1;
                        start = e.base;
                        cnt_v = e.size;
                    end
                end
                else
                begin
                    if (r_q.p1[7])
                    begin
                        hit = ef_find(1'b1, 16'h0000, r_q.p1[4:0]);
                        off = {7'h00, r_q.p2};
                        if (r_q.p1[6:5] != 2'b00 || r_q.p1[4:0] == `IFSR_SFI_RESERVED)
                        begin
                            sw_v = `IFSR_SW_BAD_PARAMS;
                        end
                        else if (r_q.p1[4:0] != `IFSR_SFI_CURRENT)
                        begin
                            if (hit[2])
                            begin
                                r_d.ef_ok = 1'b1;
                                r_d.ef_idx = hit[1:0];
                            end
                            else
                            begin
                                sw_v = `IFSR_SW_NOT_FOUND;
                            end
                        end
                    end
                    else
                    begin
                        off = {r_q.p1[6:0], r_q.p2};
                    end
                    e = ef_info(r_d.ef_idx);
                    rem = e.size - off[9:0];
                    if (sw_v != `IFSR_SW_OK)
                    begin
                        sw_v = sw_v;
                    end
                    else if (lc != 16'h0000 || !le_pres)
                    begin
                        sw_v = `IFSR_SW_BAD_LEN;
                    end
                    else if (!r_d.ef_ok || {1'b0, off} >= {6'h00, e.size})
                    begin
                        sw_v = `IFSR_SW_USE_COND;
                    end
                    else
                    begin
                        send = 1'b1;
                        start = e.base + off[8:0];
                        cnt_v = (le == 16'h0000 || le >= {6'h00, rem}) ? rem : le[9:0];
                    end
                end
                if (sw_v != `IFSR_SW_OK)
                begin
                    r_d.ef_ok = r_q.ef_ok;
                    r_d.ef_idx = r_q.ef_idx;
                    r_d.df_sel = r_q.df_sel;
                end
                r_d.sw = sw_v;
                r_d.rd_addr = start;
                r_d.rd_left = cnt_v;
                r_d.cnt = 5'h00;
                r_d.ovf = 1'b0;
                r_d.st = (send && cnt_v != 10'h000) ? IFSR_DATA : IFSR_SW1;
            end
            default:
            begin
                // output register reloads only once the current byte is gone
                if (!r_q.out_valid || rsp_ready)
                begin
                    r_d.out_valid = 1'b1;
                    r_d.out.last = 1'b0;
                    if (r_q.st == IFSR_DATA)
                    begin
                        r_d.out.data = mem[r_q.rd_addr];
                        r_d.rd_addr = r_q.rd_addr + 9'h001;
                        r_d.rd_left = r_q.rd_left - 10'h001;
                        r_d.st = (r_q.rd_left == 10'h001) ? IFSR_SW1 : IFSR_DATA;
                    end
                    else if (r_q.st == IFSR_SW1)
                    begin
                        r_d.out.data = r_q.sw[15:8];
                        r_d.st = IFSR_SW2;
                    end
                    else
                    begin
                        r_d.out.data = r_q.sw[7:0];
                        r_d.out.last = 1'b1;
                        r_d.st = IFSR_COLLECT;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // next command may stream in while the last status byte drains
    assign cmd_ready = (r_q.st == IFSR_COLLECT);
    assign rsp_out = r_q.out;
    assign rsp_valid = r_q.out_valid;
    assign df_selected = r_q.df_sel;
    assign ef_selected = r_q.ef_ok;

endmodule

// [testbench/ifsr_host.sv]
`timescale 1ns/10ps
module ifsr_host
(
    input  wire logic                 clk_sys,   // system clock
    output ifsr_pkg::ifsr_byte_t      cmd_in,    // command byte to block
    output logic                      cmd_valid, // byte offered
    input  wire logic                 cmd_ready, // byte taken
    input  wire ifsr_pkg::ifsr_byte_t rsp_out,   // response byte
    input  wire logic                 rsp_valid, // response offered
    output logic                      rsp_ready, // response taken
    input  wire logic                 slow       // stall every other cycle
);
    import ifsr_pkg::*;
    logic [7:0] rx[$];
    int         n_done;
    initial
    begin
        cmd_in    = '0;
        cmd_valid = 1'b0;
        rsp_ready = 1'b0;
        n_done    = 0;
    end
    task automatic send(input logic [7:0] q[$]);
        for (int i = 0; i < q.size(); i++)
        begin
            @(negedge clk_sys);
            cmd_valid   = 1'b1;
            cmd_in.data = q[i];
            cmd_in.last = (i == q.size() - 1);
            do @(posedge clk_sys); while (cmd_ready !== 1'b1);
        end
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        // released lines must not keep showing the last byte
        cmd_in    = ~cmd_in;
    endtask
    always @(negedge clk_sys)
        rsp_ready <= slow ? ~rsp_ready : 1'b1;
    always @(posedge clk_sys)
        if (rsp_valid && rsp_ready)
        begin
            rx.push_back(rsp_out.data);
            if (rsp_out.last)
                n_done++;
        end
endmodule

// [testbench/ifsr_top_assertions.sv]
`timescale 1ns/10ps
module ifsr_top_assertions
(
    input wire logic                 clk_sys,     // system clock
    input wire logic                 rstn,        // async reset, active low
    input wire ifsr_pkg::ifsr_byte_t cmd_in,      // command byte
    input wire logic                 cmd_valid,   // command byte offered
    input wire logic                 cmd_ready,   // command byte taken
    input wire ifsr_pkg::ifsr_byte_t rsp_out,     // response byte
    input wire logic                 rsp_valid,   // response byte offered
    input wire logic                 rsp_ready,   // response byte taken
    input wire logic                 chain_busy,  // chain ongoing
    input wire ifsr_pkg::ifsr_load_t mem_load,    // file load port
    input wire logic                 df_selected, // DF current
    input wire logic                 ef_selected  // EF current
);
    import ifsr_pkg::*;
    logic [1:0] idx_q;
    logic [7:0] cla_q;
    logic [7:0] ins_q;
    logic [7:0] cla_c;
    logic       take;
    assign take  = cmd_valid && cmd_ready;
    // a one-byte command has its class byte still on the wire
    assign cla_c = (idx_q == 2'h0) ? cmd_in.data : cla_q;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            idx_q <= 2'h0;
            cla_q <= 8'h00;
            ins_q <= 8'h00;
        end
        else if (take)
        begin
            idx_q <= cmd_in.last ? 2'h0 : ((idx_q == 2'h3) ? 2'h3 : idx_q + 2'h1);
            if (idx_q == 2'h0)
                cla_q <= cmd_in.data;
            if (idx_q == 2'h1)
                ins_q <= cmd_in.data;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_out);
    endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("response byte moved before taken");
    property p_turn;
        take && cmd_in.last |=> !cmd_ready [*2] ##1 (rsp_valid && !cmd_ready);
    endproperty
    a_turn: assert property (p_turn) else $error("response late after last byte");
    property p_first;
        $rose(rsp_valid) |-> !rsp_out.last;
    endproperty
    a_first: assert property (p_first) else $error("response began with its final byte");
    property p_end;
        rsp_valid && rsp_ready && rsp_out.last |=> !rsp_valid;
    endproperty
    a_end: assert property (p_end) else $error("response continued after status word");
    property p_busy;
        rsp_valid && !rsp_out.last && !rsp_ready |=> !cmd_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("command port open mid response");
    property p_sel;
        $changed(df_selected) || $changed(ef_selected) |-> rsp_valid || !cmd_ready;
    endproperty
    a_sel: assert property (p_sel) else $error("selection moved outside a command");
    property p_chain;
        take && cmd_in.last && chain_busy && idx_q == 2'h3 && cla_c == 8'h00
            && (ins_q == 8'hA4 || ins_q == 8'hB0) |=> ##2 rsp_valid && rsp_out.data == 8'h69;
    endproperty
    a_chain: assert property (p_chain) else $error("chain in progress not refused");
    property p_class;
        take && cmd_in.last && cla_c != 8'h00 |=> ##2 rsp_valid && rsp_out.data == 8'h6E;
    endproperty
    a_class: assert property (p_class) else $error("wrong class not refused");
    property p_reset;
        $rose(rstn) |-> cmd_ready && !rsp_valid && !df_selected && !ef_selected;
    endproperty
    a_reset: assert property (p_reset) else $error("state after reset wrong");
    c_chain: cover property (take && cmd_in.last && chain_busy);
    c_class: cover property (take && cmd_in.last && cla_c != 8'h00);
    c_data: cover property (rsp_valid && rsp_ready && !rsp_out.last ##1 rsp_valid && !rsp_out.last);
    c_df: cover property ($rose(df_selected));
endmodule

bind ifsr_top ifsr_top_assertions u_chk
(
    .clk_sys(clk_sys), .rstn(rstn), .cmd_in(cmd_in), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .rsp_out(rsp_out), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .chain_busy(chain_busy),
    .mem_load(mem_load), .df_selected(df_selected), .ef_selected(ef_selected)
);

// [testbench/ifsr_top_test.sv]
`timescale 1ns/10ps
`include "ifsr_params.svh"
module ifsr_top_test;
    import ifsr_pkg::*;
    logic       clk_sys;
    logic       rstn;
    ifsr_byte_t cmd_in;
    logic       cmd_valid;
    logic       cmd_ready;
    ifsr_byte_t rsp_out;
    logic       rsp_valid;
    logic       rsp_ready;
    logic       chain_busy;
    ifsr_load_t mem_load;
    logic       df_selected;
    logic       ef_selected;
    logic       slow;
    logic [7:0] nd[$];
    int         mismatches;
    int         n_tests;
    int         cyc;
    ifsr_top dut (.clk_sys(clk_sys), .rstn(rstn), .cmd_in(cmd_in), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .rsp_out(rsp_out), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .chain_busy(chain_busy), .mem_load(mem_load), .df_selected(df_selected), .ef_selected(ef_selected));
    ifsr_host host (.clk_sys(clk_sys), .cmd_in(cmd_in), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .rsp_out(rsp_out), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .slow(slow));
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] pat(input int a);
        return 8'(a * 7 + 3);
    endfunction
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic run(input logic [7:0] q[$], input logic [7:0] d[$], input logic [15:0] sw);
        int         w;
        logic [7:0] exp[$];
        exp = d;
        exp.push_back(sw[15:8]);
        exp.push_back(sw[7:0]);
        host.rx.delete();
        w = host.n_done;
        host.send(q);
        for (int k = 0; k < 3000 && host.n_done == w; k++)
            @(posedge clk_sys);
        @(negedge clk_sys);
        check("rsp_len", 16'(host.rx.size()), 16'(exp.size()));
        for (int i = 0; i < exp.size() && i < host.rx.size(); i++)
            check("rsp_byte", {8'h00, host.rx[i]}, {8'h00, exp[i]});
    endtask
    task automatic rd(input logic [7:0] q[$], input int base, input int n);
        logic [7:0] d[$];
        for (int i = 0; i < n; i++)
            d.push_back(pat(base + i));
        run(q, d, `IFSR_SW_OK);
    endtask
    task automatic sel(input logic [7:0] q[$], input logic [15:0] sw, input logic df);
        run(q, nd, sw);
        check("df_selected", {15'h0, df_selected}, {15'h0, df});
    endtask
    task t_errors;
        run('{8'h80, 8'hA4, 8'h00, 8'h0C}, nd, `IFSR_SW_BAD_CLASS);
        run('{8'h00, 8'hA4, 8'h00}, nd, `IFSR_SW_BAD_LEN);
        run('{8'h00, 8'hCA, 8'h00, 8'h0C}, nd, `IFSR_SW_BAD_INS);
        chain_busy = 1'b1;
        run('{8'h00, 8'hA4, 8'h00, 8'h0C}, nd, `IFSR_SW_USE_COND);
        chain_busy = 1'b0;
        run('{8'h00, 8'hB0, 8'h00, 8'h00, 8'h00}, nd, `IFSR_SW_USE_COND);
    endtask
    task t_select;
        sel('{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'hE1, 8'h10}, `IFSR_SW_OK, 1'b1);
        sel('{8'h00, 8'hA4, 8'h02, 8'h0C, 8'h02, 8'hE1, 8'h03}, `IFSR_SW_OK, 1'b1);
        check("ef_selected", {15'h0, ef_selected}, 16'h0001);
        sel('{8'h00, 8'hA4, 8'h03, 8'h0C}, `IFSR_SW_OK, 1'b0);
        sel('{8'h00, 8'hA4, 8'h02, 8'h0C, 8'h02, 8'hE1, 8'h04}, `IFSR_SW_NOT_FOUND, 1'b0);
        sel('{8'h00, 8'hA4, 8'h01, 8'h0C, 8'h02, 8'hE1, 8'h10}, `IFSR_SW_OK, 1'b1);
        sel('{8'h00, 8'hA4, 8'h00, 8'h0C}, `IFSR_SW_OK, 1'b0);
        sel('{8'h00, 8'hA4, 8'h04, 8'h0C, 8'h07, 8'hA0, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04},
            `IFSR_SW_OK, 1'b1);
        sel('{8'h00, 8'hA4, 8'h02, 8'h0C, 8'h02, 8'h12, 8'h34}, `IFSR_SW_NOT_FOUND, 1'b1);
        sel('{8'h00, 8'hA4, 8'h05, 8'h0C}, `IFSR_SW_BAD_PARAMS, 1'b1);
        sel('{8'h00, 8'hA4, 8'h00, 8'h01, 8'h02, 8'h3F, 8'h00}, `IFSR_SW_BAD_PARAMS, 1'b1);
        sel('{8'h00, 8'hA4, 8'h01, 8'h0C, 8'h01, 8'hE1}, `IFSR_SW_LEN_PARAM, 1'b1);
        sel('{8'h00, 8'hA4, 8'h03, 8'h0C, 8'h02, 8'h3F, 8'h00}, `IFSR_SW_LEN_PARAM, 1'b1);
        sel('{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'h3F, 8'h00}, `IFSR_SW_OK, 1'b0);
    endtask
    task t_fci;
        slow = 1'b1;
        rd('{8'h00, 8'hA4, 8'h01, 8'h00, 8'h02, 8'hE1, 8'h10}, 'h1C0, 32);
        slow = 1'b0;
        run('{8'h00, 8'hA4, 8'h02, 8'h0C, 8'h02, 8'hE1, 8'h04}, nd, `IFSR_SW_OK);
    endtask
    task t_read;
        rd('{8'h00, 8'hB0, 8'h82, 8'h3C, 8'h00}, 'h0BC, 4);
        rd('{8'h00, 8'hB0, 8'h00, 8'h10, 8'h08}, 'h090, 8);
        rd('{8'h00, 8'hB0, 8'h00, 8'h30, 8'hFF}, 'h0B0, 16);
        rd('{8'h00, 8'hB0, 8'h00, 8'h3E, 8'h00, 8'h00, 8'h00}, 'h0BE, 2);
        rd('{8'h00, 8'hB0, 8'h80, 8'h00, 8'h04}, 'h080, 4);
        run('{8'h00, 8'hB0, 8'h00, 8'h40, 8'h00}, nd, `IFSR_SW_USE_COND);
        run('{8'h00, 8'hB0, 8'h9F, 8'h00, 8'h00}, nd, `IFSR_SW_BAD_PARAMS);
        run('{8'h00, 8'hB0, 8'hA2, 8'h00, 8'h00}, nd, `IFSR_SW_BAD_PARAMS);
        run('{8'h00, 8'hB0, 8'h85, 8'h00, 8'h00}, nd, `IFSR_SW_NOT_FOUND);
        run('{8'h00, 8'hB0, 8'h00, 8'h00}, nd, `IFSR_SW_BAD_LEN);
    endtask
    task t_reset;
        rstn = 1'b0;
        repeat (3) @(negedge clk_sys);
        check("df_after_reset", {15'h0, df_selected}, 16'h0000);
        check("ready_after_reset", {15'h0, cmd_ready}, 16'h0001);
        rstn = 1'b1;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    initial
    begin
        rstn       = 1'b0;
        chain_busy = 1'b0;
        slow       = 1'b0;
        mem_load   = '0;
        repeat (10) @(negedge clk_sys);
        rstn = 1'b1;
        for (int a = 0; a < `IFSR_MEM_DEPTH; a++)
        begin
            @(negedge clk_sys);
            mem_load.we    = 1'b1;
            mem_load.addr  = 9'(a);
            mem_load.wdata = pat(a);
        end
        @(negedge clk_sys);
        mem_load.we = 1'b0;
        t_errors();
        t_select();
        t_fci();
        t_read();
        t_reset();
        wrap_up();
    end
endmodule
